//--- csd_core.sv
// Execute core for compare-skip, decimal adjust and decrement.
`timescale 1ns/1ps
`default_nettype none
`include "csd_defs.svh"
module csd_core
	import csd_pkg::*;
(
	// Clock and reset.
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// Instruction stream from fetch.
	input  wire logic        instr_valid,
	input  wire logic [23:0] instr_word,
	input  wire logic        next_two_word,
	output logic             instr_ready,
	output logic             flush_next,
	output logic             nop_exec,
	// Working register file.
	output logic [3:0]       rf_ra_addr,
	input  wire logic [15:0] rf_ra_data,
	output logic [3:0]       rf_rb_addr,
	input  wire logic [15:0] rf_rb_data,
	output logic             rf_we,
	output logic             rf_wbyte,
	output logic [3:0]       rf_waddr,
	output logic [15:0]      rf_wdata,
	// Data memory.
	output logic             mem_re,
	output logic             mem_we,
	output logic             mem_byte,
	output logic [15:0]      mem_addr,
	output logic [15:0]      mem_wdata,
	input  wire logic [15:0] mem_rdata,
	// Status word flags.
	input  wire csd_flags_t  status_word_in,
	output logic [4:0]       status_word_we,
	output csd_flags_t       status_word_out
);

	// ****************************************************************
	// Declarations
	// ****************************************************************

	csd_core_t   q;         // Registered state.
	csd_core_t   n;         // Next state.
	csd_dec_if   dif ();    // Decoded fields of the offered word.
	logic [15:0] alu_a;     // First operand to the arithmetic.
	logic [15:0] alu_b;     // Second operand to the arithmetic.
	logic [15:0] alu_res;   // Arithmetic result.
	csd_flags_t  alu_fl;    // Flags from the arithmetic.
	logic        alu_take;  // Compare relation holds.
	logic        src_mem;   // Decrement operand comes from memory.
	logic [15:0] dec_in;    // Operand for the decrement step.

	// Reset image: idle, no strobes, no flags written.
	localparam csd_core_t CSD_CORE_RST = csd_core_t'('0);

	// ****************************************************************
	// Helper functions
	// ****************************************************************

	// Pointer step is one byte or one word.
	function automatic logic [15:0] step_of(input logic b);
		return b ? `CSD_STEP_B : `CSD_STEP_W;
	endfunction

	// Pointer value after its own increment or decrement.
	function automatic logic [15:0] ptr_next(input logic [15:0] w,
		input logic [2:0] m, input logic b);
		logic [15:0] r;
		r = w;
		case (m)
			`CSD_AM_POSTI, `CSD_AM_PREI: r = w + step_of(b);
			`CSD_AM_POSTD, `CSD_AM_PRED: r = w - step_of(b);
			default: r = w;
		endcase
		return r;
	endfunction

	// Address used for the access: pre-modified or as held.
	function automatic logic [15:0] eff_addr(input logic [15:0] w,
		input logic [2:0] m, input logic b);
		logic [15:0] r;
		r = w;
		if (m == `CSD_AM_PREI || m == `CSD_AM_PRED)
			r = ptr_next(w, m, b);
		return r;
	endfunction

	// True when the mode writes the pointer back.
	function automatic logic ptr_upd(input logic [2:0] m);
		return m >= `CSD_AM_POSTI && m <= `CSD_AM_PRED;
	endfunction

	// ****************************************************************
	// Sub-blocks
	// ****************************************************************

	// Decoder looks at the word on offer in the idle state.
	csd_decode u_dec (
		.instr_word (instr_word),
		.dec        (dif.dec)
	);

	// Shared arithmetic for compare, adjust and decrement.
	csd_alu u_alu (
		.op      (q.op),
		.byte_m  (q.byte_m),
		.opa     (alu_a),
		.opb     (alu_b),
		.fin     (status_word_in),
		.res     (alu_res),
		.fout    (alu_fl),
		.take    (alu_take)
	);

	// ****************************************************************
	// Operand selection
	// ****************************************************************

	// In the result state the decrement runs on the memory data, or on the
	// latched register operand for a direct source; otherwise the two
	// register read ports feed the arithmetic.
	always_comb begin
		src_mem = (q.op == CSD_OP_DECF) || (q.mode_s != `CSD_AM_DIR);
		dec_in  = src_mem ? mem_rdata : q.opnd;
		if (q.st == CSD_ST_RES) begin
			alu_a = dec_in;
			alu_b = `CSD_DEC_ONE; // [RL8]
		end else begin
			alu_a = rf_ra_data; // [RL1]
			alu_b = rf_rb_data; // [RL1]
		end
	end

	// ****************************************************************
	// Sequencer
	// ****************************************************************

	// One process builds the next state; strobes default low so each
	// lasts one cycle unless the next state sets it again.
	always_comb begin
		n        = q;
		n.rf_we  = 1'b0;
		n.mem_re = 1'b0;
		n.mem_we = 1'b0;
		n.sw_we  = 5'h00;
		n.flush  = 1'b0;
		n.nop    = 1'b0;
		case (q.st)
			CSD_ST_IDLE: begin
				// Words outside this group are left to other units.
				if (instr_valid && dif.op != CSD_OP_NONE) begin
					n.st       = CSD_ST_OPER;
					n.op       = dif.op;
					n.byte_m   = dif.byte_m;
					n.dst_f    = dif.dst_f;
					n.mode_s   = dif.mode_s;
					n.mode_d   = dif.mode_d;
					n.rs       = dif.rs;
					n.rd       = dif.rd;
					n.faddr    = dif.faddr;
					n.two_next = next_two_word;
				end
			end
			CSD_ST_OPER: begin
				n.vs = rf_ra_data;
				n.vd = rf_rb_data;
				n.st = CSD_ST_IDLE;
				case (q.op)
					CSD_OP_GT, CSD_OP_LT, CSD_OP_NE: begin
						// Nothing is written and no flag changes.
						if (alu_take) begin
							n.flush   = 1'b1; // [RL2]
							n.nop     = 1'b1; // [RL2]
							n.nop_cnt = q.two_next ? 2'd2 : 2'd1; // [RL3]
							n.st      = CSD_ST_SKIP;
						end
					end
					CSD_OP_DADJ: begin
						n.rf_we    = 1'b1;
						n.rf_wbyte = 1'b1;
						n.rf_wa    = q.rs;
						n.rf_wd    = alu_res; // [RL7]
						n.sw_we    = 5'b00001; // [RL7]
						n.sw_fl    = alu_fl;
					end
					CSD_OP_DECF: begin
						n.mem_re = 1'b1; // [RL8]
						n.mem_a  = {3'b000, q.faddr};
						n.st     = CSD_ST_MRD;
					end
					CSD_OP_DECW: begin
						n.ea_d = eff_addr(rf_rb_data, q.mode_d, q.byte_m);
						if (q.mode_s == `CSD_AM_DIR) begin
							n.opnd = rf_ra_data;
							n.st   = CSD_ST_RES;
						end else begin
							n.mem_re = 1'b1;
							n.mem_a  = eff_addr(rf_ra_data, q.mode_s,
								q.byte_m); // [RL11]
							n.st     = CSD_ST_MRD;
						end
					end
					default: n.st = CSD_ST_IDLE;
				endcase
			end
			CSD_ST_MRD: begin
				// Read strobe is out; data stand in the next cycle.
				n.st = CSD_ST_RES;
			end
			CSD_ST_RES: begin
				n.sw_we = 5'b11111; // [RL12]
				n.sw_fl = alu_fl;   // [RL12]
				n.st    = CSD_ST_IDLE;
				if (q.op == CSD_OP_DECF) begin
					if (q.dst_f) begin
						n.mem_we = 1'b1; // [RL9]
						n.mem_a  = {3'b000, q.faddr};
						n.mem_wd = alu_res;
					end else begin
						n.rf_we    = 1'b1;
						n.rf_wbyte = q.byte_m;
						n.rf_wa    = `CSD_DEF_WORK; // [RL9]
						n.rf_wd    = alu_res;
					end
				end else begin
					if (q.mode_d == `CSD_AM_DIR) begin
						n.rf_we    = 1'b1;
						n.rf_wbyte = q.byte_m;
						n.rf_wa    = q.rd; // [RL11]
						n.rf_wd    = alu_res;
					end else begin
						n.mem_we = 1'b1;
						n.mem_a  = q.ea_d; // [RL11]
						n.mem_wd = alu_res;
					end
					if (ptr_upd(q.mode_s))
						n.st = CSD_ST_PTRS;
					else if (ptr_upd(q.mode_d))
						n.st = CSD_ST_PTRD;
				end
			end
			CSD_ST_PTRS: begin
				// Pointers are written as full words, one write a cycle.
				n.rf_we    = 1'b1;
				n.rf_wbyte = 1'b0;
				n.rf_wa    = q.rs;
				n.rf_wd    = ptr_next(q.vs, q.mode_s, q.byte_m);
				n.st       = ptr_upd(q.mode_d) ? CSD_ST_PTRD :
					CSD_ST_IDLE;
			end
			CSD_ST_PTRD: begin
				// Same register as source ends with this write, made from the older value.
				n.rf_we    = 1'b1;
				n.rf_wbyte = 1'b0;
				n.rf_wa    = q.rd;
				n.rf_wd    = ptr_next(q.vd, q.mode_d, q.byte_m);
				n.st       = CSD_ST_IDLE;
			end
			CSD_ST_SKIP: begin
				// A two-word successor costs a second no-op.
				n.nop_cnt = q.nop_cnt - 2'd1;
				if (q.nop_cnt == 2'd1) begin
					n.st = CSD_ST_IDLE; // [RL3]
				end else begin
					n.nop = 1'b1; // [RL3]
				end
			end
			default: n = CSD_CORE_RST;
		endcase
	end

	// ****************************************************************
	// State register
	// ****************************************************************

	// Synchronous reset brings the core to idle with strobes low.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			q <= CSD_CORE_RST;
		end else begin
			q <= n;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************

	// Ready is a handshake and may follow the state directly.
	assign instr_ready     = (q.st == CSD_ST_IDLE);
	assign flush_next      = q.flush;
	assign nop_exec        = q.nop;
	assign rf_ra_addr      = q.rs;
	assign rf_rb_addr      = q.rd;
	assign rf_we           = q.rf_we;
	assign rf_wbyte        = q.rf_wbyte;
	assign rf_waddr        = q.rf_wa;
	assign rf_wdata        = q.rf_wd;
	assign mem_re          = q.mem_re;
	assign mem_we          = q.mem_we;
	assign mem_byte        = q.byte_m;
	assign mem_addr        = q.mem_a;
	assign mem_wdata       = q.mem_wd;
	assign status_word_we  = q.sw_we;
	assign status_word_out = q.sw_fl;

endmodule
`default_nettype wire

//--- csd_defs.svh
// Constants for the compare-skip, decimal adjust and decrement block.
//
// Behaviour
// RL1: Compare subtracts, stores nothing, keeps flags.
// RL2: True relation discards next instruction, runs no-op.
// RL3: Compare: one cycle, two or three skipping.
// RL4: Size bit zero word, one byte.
// RL5: Four w bits, four s bits pick registers.
// RL6: Opcodes 0110_0 greater, 0110_1 less, 0111_0 unequal.
// RL7: Decimal adjust adds six per nibble, carry rollover.
// RL8: File decrement subtracts one from memory location.
// RL9: Destination bit zero writes default register.
// RL10: File decrement encoding 1110_1101_0, B, D, f.
// RL11: Register decrement encoding with modes, writes source-1.
// RL12: Decrements update all five status flags.
`ifndef CSD_DEFS_SVH
`define CSD_DEFS_SVH

// ****************************************************************
// Opcode patterns
// ****************************************************************
`define CSD_CMP_PFX   4'hE
`define CSD_CMP_GT    5'h0C
`define CSD_CMP_LT    5'h0D
`define CSD_CMP_NE    5'h0E
`define CSD_DADJ_PAT  20'hFD400
`define CSD_DECF_PAT  9'h1DA
`define CSD_DECW_PAT  9'h1D2

// ****************************************************************
// Operand constants
// ****************************************************************
`define CSD_DEF_WORK  4'h0
`define CSD_BCD_MAX   4'h9
`define CSD_BCD_LO    9'h006
`define CSD_BCD_HI    9'h060
`define CSD_DEC_ONE   16'h0001
`define CSD_STEP_B    16'h0001
`define CSD_STEP_W    16'h0002
`define CSD_FADDR_W   13

// ****************************************************************
// Addressing modes of the register decrement
// ****************************************************************
`define CSD_AM_DIR    3'h0
`define CSD_AM_IND    3'h1
`define CSD_AM_POSTI  3'h2
`define CSD_AM_POSTD  3'h3
`define CSD_AM_PREI   3'h4
`define CSD_AM_PRED   3'h5

`endif

//--- csd_pkg.sv
// Types shared by the compare-skip and decrement block.
package csd_pkg;

	// Decoded operation.
	typedef enum logic [2:0] {
		CSD_OP_NONE = 3'b000,
		CSD_OP_GT   = 3'b001,
		CSD_OP_LT   = 3'b010,
		CSD_OP_NE   = 3'b011,
		CSD_OP_DADJ = 3'b100,
		CSD_OP_DECF = 3'b101,
		CSD_OP_DECW = 3'b110
	} csd_op_t;

	// Status flags in the order digit carry, N, overflow, Z, C.
	typedef struct packed {
		logic dcar;
		logic n;
		logic ovf;
		logic z;
		logic c;
	} csd_flags_t;

	// Sequencer states.
	typedef enum logic [2:0] {
		CSD_ST_IDLE = 3'b000,
		CSD_ST_OPER = 3'b001,
		CSD_ST_MRD  = 3'b010,
		CSD_ST_RES  = 3'b011,
		CSD_ST_PTRS = 3'b100,
		CSD_ST_PTRD = 3'b101,
		CSD_ST_SKIP = 3'b110
	} csd_state_t;

	// Whole state of the core.
	typedef struct packed {
		csd_state_t st;
		csd_op_t    op;
		logic       byte_m;
		logic       dst_f;
		logic [2:0] mode_s;
		logic [2:0] mode_d;
		logic [3:0] rs;
		logic [3:0] rd;
		logic [12:0] faddr;
		logic       two_next;
		logic [1:0] nop_cnt;
		logic [15:0] vs;
		logic [15:0] vd;
		logic [15:0] opnd;
		logic [15:0] ea_d;
		logic       rf_we;
		logic       rf_wbyte;
		logic [3:0] rf_wa;
		logic [15:0] rf_wd;
		logic       mem_re;
		logic       mem_we;
		logic [15:0] mem_a;
		logic [15:0] mem_wd;
		logic [4:0] sw_we;
		csd_flags_t sw_fl;
		logic       flush;
		logic       nop;
	} csd_core_t;

endpackage

//--- csd_dec_if.sv
// Decoded instruction fields passed from the decoder to the core.
`timescale 1ns/1ps
`default_nettype none
interface csd_dec_if;
	import csd_pkg::*;
	csd_op_t     op;      // Decoded operation.
	logic        byte_m;  // Byte width selected.
	logic        dst_f;   // File register is the destination.
	logic [2:0]  mode_s;  // Source addressing mode.
	logic [2:0]  mode_d;  // Destination addressing mode.
	logic [3:0]  rs;      // First or source register.
	logic [3:0]  rd;      // Second or destination register.
	logic [12:0] faddr;   // File register address.

	modport dec (output op, byte_m, dst_f, mode_s, mode_d, rs, rd, faddr);
	modport core (input op, byte_m, dst_f, mode_s, mode_d, rs, rd, faddr);
endinterface
`default_nettype wire

//--- csd_decode.sv
// Instruction decoder for the compare-skip and decrement group.
`timescale 1ns/1ps
`default_nettype none
`include "csd_defs.svh"
module csd_decode
	import csd_pkg::*;
(
	// Fetched instruction word.
	input wire logic [23:0] instr_word,
	// Decoded fields.
	csd_dec_if.dec          dec
);

	// ****************************************************************
	// Opcode match
	// ****************************************************************

	// Classify the word; unmatched words give no operation.
	function automatic csd_op_t classify(input logic [23:0] w);
		csd_op_t o;
		o = CSD_OP_NONE;
		// Compares need zeros in bits 9:4 besides the pattern.
		if (w[23:20] == `CSD_CMP_PFX && w[9:4] == 6'h00) begin
			case (w[19:15]) // [RL6]
				`CSD_CMP_GT: o = CSD_OP_GT;
				`CSD_CMP_LT: o = CSD_OP_LT;
				`CSD_CMP_NE: o = CSD_OP_NE;
				default:     o = CSD_OP_NONE;
			endcase
		end
		if (w[23:4] == `CSD_DADJ_PAT)
			o = CSD_OP_DADJ;
		if (w[23:15] == `CSD_DECF_PAT)
			o = CSD_OP_DECF; // [RL10]
		if (w[23:15] == `CSD_DECW_PAT)
			o = CSD_OP_DECW; // [RL11]
		return o;
	endfunction

	// ****************************************************************
	// Field extraction
	// ****************************************************************

	// Fields sit at fixed places; register picks depend on the form.
	always_comb begin
		dec.op     = classify(instr_word);
		dec.byte_m = (dec.op == CSD_OP_DECF || dec.op == CSD_OP_DECW) ?
			instr_word[14] : instr_word[10]; // [RL4]
		dec.dst_f  = instr_word[13]; // [RL9]
		dec.mode_d = instr_word[13:11];
		dec.mode_s = instr_word[6:4];
		dec.faddr  = instr_word[12:0];
		dec.rs     = instr_word[3:0];
		dec.rd     = instr_word[10:7];
		if (dec.op == CSD_OP_GT || dec.op == CSD_OP_LT ||
			dec.op == CSD_OP_NE) begin
			dec.rs = instr_word[14:11]; // [RL5]
			dec.rd = instr_word[3:0];   // [RL5]
		end
	end

endmodule
`default_nettype wire

//--- csd_alu.sv
// Subtract, compare and decimal adjust arithmetic.
`timescale 1ns/1ps
`default_nettype none
`include "csd_defs.svh"
module csd_alu
	import csd_pkg::*;
(
	// Operation select.
	input  wire logic [2:0]  op,
	input  wire logic        byte_m,
	// Operands and incoming flags.
	input  wire logic [15:0] opa,
	input  wire logic [15:0] opb,
	input  wire csd_flags_t  fin,
	// Result, flags and compare outcome.
	output logic [15:0]      res,
	output csd_flags_t       fout,
	output logic             take
);

	logic [8:0]  d8;   // Low byte difference with borrow.
	logic [16:0] d16;  // Word difference with borrow.
	logic [4:0]  d4;   // Low nibble difference with borrow.
	logic [8:0]  t9;   // Byte after low nibble adjust.
	logic [8:0]  u9;   // Byte after high nibble adjust.
	logic        sa;   // Sign of first operand at width.
	logic        sb;   // Sign of second operand at width.
	logic        sd;   // Sign of difference at width.
	csd_flags_t  fs;   // Flags of the subtraction.

	// ****************************************************************
	// Subtraction at byte or word width
	// ****************************************************************

	// The low byte borrow doubles as the word digit carry.
	always_comb begin
		d4  = {1'b0, opa[3:0]} - {1'b0, opb[3:0]};
		d8  = {1'b0, opa[7:0]} - {1'b0, opb[7:0]};
		d16 = {1'b0, opa} - {1'b0, opb};
		sa  = byte_m ? opa[7] : opa[15]; // [RL4]
		sb  = byte_m ? opb[7] : opb[15];
		sd  = byte_m ? d8[7] : d16[15];
		fs.n  = sd;                                     // [RL12]
		fs.ovf = (sa != sb) && (sd != sa);              // [RL12]
		fs.z  = byte_m ? (d8[7:0] == 8'h00) : (d16[15:0] == 16'h0000);
		fs.c  = byte_m ? ~d8[8] : ~d16[16];             // [RL12]
		fs.dcar = byte_m ? ~d4[4] : ~d8[8];             // [RL12]
	end

	// ****************************************************************
	// Decimal adjust and output select
	// ****************************************************************

	// Low nibble first so its carry reaches the high nibble test.
	always_comb begin
		t9 = {1'b0, opa[7:0]};
		if (opa[3:0] > `CSD_BCD_MAX || fin.dcar)
			t9 = t9 + `CSD_BCD_LO; // [RL7]
		u9 = t9;
		if (t9[7:4] > `CSD_BCD_MAX || fin.c || t9[8])
			u9 = t9 + `CSD_BCD_HI; // [RL7]
		fout = fs;
		res  = byte_m ? {opa[15:8], d8[7:0]} : d16[15:0];
		take = 1'b0;
		case (csd_op_t'(op))
			CSD_OP_GT: take = ~fs.z && (fs.n == fs.ovf); // [RL2]
			CSD_OP_LT: take = (fs.n != fs.ovf);          // [RL2]
			CSD_OP_NE: take = ~fs.z;                     // [RL2]
			CSD_OP_DADJ: begin
				res    = {opa[15:8], u9[7:0]};
				fout   = fin;
				fout.c = fin.c | u9[8]; // [RL7]
			end
			default: take = 1'b0;
		endcase
	end

endmodule
`default_nettype wire

//--- csd_monitor.sv
// Concurrent checks on the ports of the execute core.
`timescale 1ns/1ps
`default_nettype none
module csd_monitor
	import csd_pkg::*;
(
	// Clock and reset.
	input wire logic        mclk,
	input wire logic        rst_n,
	// Instruction stream.
	input wire logic        instr_valid,
	input wire logic [23:0] instr_word,
	input wire logic        next_two_word,
	input wire logic        instr_ready,
	input wire logic        flush_next,
	input wire logic        nop_exec,
	// Working registers.
	input wire logic [3:0]  rf_ra_addr,
	input wire logic [15:0] rf_ra_data,
	input wire logic [3:0]  rf_rb_addr,
	input wire logic [15:0] rf_rb_data,
	input wire logic        rf_we,
	input wire logic        rf_wbyte,
	input wire logic [3:0]  rf_waddr,
	// Data memory and flags.
	input wire logic        mem_re,
	input wire logic        mem_we,
	input wire logic        mem_byte,
	input wire logic [15:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	input wire logic [15:0] mem_rdata,
	input wire logic [4:0]  status_word_we
);
	// ******************************************************
	// Helper logic
	// ******************************************************
	logic        acc;    // A word is taken on this edge.
	logic        is_cmp; // The offered word is a compare-skip.
	logic [23:0] word_q; // Last word taken.
	logic        take_q; // Relation seen in the execute cycle.

	assign acc = instr_valid && instr_ready;
	assign is_cmp = instr_word[23:20] == 4'hE && instr_word[9:4] == 6'h00
		&& (instr_word[19:15] inside {5'h0C, 5'h0D, 5'h0E});

	// Signed relation at the width chosen by the size bit.
	function automatic logic rel(input logic [15:0] a,
		input logic [15:0] b, input logic [23:0] w);
		logic signed [16:0] sa;
		logic signed [16:0] sb;
		sa = w[10] ? {{9{a[7]}}, a[7:0]} : {a[15], a};
		sb = w[10] ? {{9{b[7]}}, b[7:0]} : {b[15], b};
		case (w[19:15])
			5'h0C: rel = sa > sb;
			5'h0D: rel = sa < sb;
			default: rel = sa != sb;
		endcase
	endfunction

	// Relation held one cycle to meet the skip pulse.
	always_ff @(posedge mclk) begin
		if (acc) begin
			word_q <= instr_word;
		end
		take_q <= rel(rf_ra_data, rf_rb_data, word_q);
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// ******************************************************
	// Assertions
	// ******************************************************
	a_cmp_no_store: assert property (acc && is_cmp |=> (!rf_we && !mem_we
		&& status_word_we == 5'h00) [*3])
		else $error("compare stored");
	a_skip_on_rel: assert property (acc && is_cmp |=> ##1
		(flush_next == take_q && nop_exec == take_q))
		else $error("skip mismatch");
	a_skip_two_cyc: assert property (acc && is_cmp && next_two_word |=>
		##1 flush_next |=> nop_exec ##1 (instr_ready && !nop_exec))
		else $error("two-word skip length");
	a_skip_one_cyc: assert property (acc && is_cmp && !next_two_word |=>
		##1 flush_next |=> (instr_ready && !nop_exec))
		else $error("one-word skip length");
	a_no_skip_fast: assert property (acc && is_cmp |=>
		##1 (flush_next || instr_ready))
		else $error("slow compare");
	a_cmp_reg_sel: assert property (acc && is_cmp |=> rf_ra_addr ==
		word_q[14:11] && rf_rb_addr == word_q[3:0])
		else $error("compare registers");
	a_adjust_write: assert property (acc && instr_word[23:4] ==
		20'hFD400 |=> ##1 (rf_we && rf_wbyte && rf_waddr == word_q[3:0]
		&& status_word_we == 5'h01))
		else $error("adjust write");
	a_file_read: assert property (acc && instr_word[23:15] == 9'h1DA
		|=> ##1 (mem_re && mem_byte == word_q[14]
		&& mem_addr == {3'h0, word_q[12:0]}))
		else $error("file read");
	a_file_dest: assert property (acc && instr_word[23:15] == 9'h1DA
		|=> ##3 (status_word_we == 5'h1F && (word_q[13] ? (mem_we && !rf_we)
		: (rf_we && !mem_we && rf_waddr == 4'h0))))
		else $error("file destination");
	a_file_value: assert property (acc && instr_word[23:13] == 11'h769
		|=> ##3 mem_wdata == $past(mem_rdata) - 16'h0001)
		else $error("file value");
	a_reg_dec_dir: assert property (acc && instr_word[23:15] == 9'h1D2
		&& instr_word[13:11] == 3'h0 && instr_word[6:4] == 3'h0 |=> ##2
		(rf_we && rf_waddr == word_q[10:7] && status_word_we == 5'h1F))
		else $error("register write");
endmodule

bind csd_core csd_monitor u_mon (.*);
`default_nettype wire

//--- testbench.sv
// Self-checking testbench for the execute core.
`timescale 1ns/1ps
`default_nettype none
module testbench
	import csd_pkg::*;
;
	// One compare case: word, operands, next size, skip expected.
	typedef struct {
		logic [23:0] w;
		logic [15:0] a;
		logic [15:0] b;
		logic        two;
		logic        take;
	} csd_row_t;

	logic        mclk, rst_n, instr_valid, next_two_word, instr_ready;
	logic        flush_next, nop_exec, rf_we, rf_wbyte, mem_re, mem_we;
	logic        mem_byte;
	logic [23:0] instr_word;
	logic [3:0]  rf_ra_addr, rf_rb_addr, rf_waddr, rw_a;
	logic [15:0] rf_ra_data, rf_rb_data, rf_wdata, mem_addr, mem_wdata;
	logic [15:0] mem_rdata, mem_val, rw_d, mw_a, mw_d;
	logic [15:0] rf [16];
	logic [4:0]  status_word_we, swe;
	csd_flags_t  status_word_in, status_word_out, sfl;
	int          n_errors, tests_run, n_fl, n_nop, n_rw, n_mw, k;
	csd_row_t    rows [7];
	logic [19:0] dadj_t [4] = '{20'h1A200, 20'hAA102, 20'h090F8, 20'h45A56};
	logic [23:0] bad [2];

	csd_core dut (.*);

	// Register file reads are combinational.
	assign rf_ra_data = rf[rf_ra_addr];
	assign rf_rb_data = rf[rf_rb_addr];

	always #50 mclk = ~mclk;

	// Memory answers a cycle after a read; pulses are recorded here.
	always @(posedge mclk) begin
		mem_rdata <= mem_re ? mem_val : ~mem_rdata;
		if (flush_next) n_fl++;
		if (nop_exec) n_nop++;
		if (rf_we) begin
			n_rw++;
			rw_a = rf_waddr;
			rw_d = rf_wdata;
		end
		if (mem_we) begin
			n_mw++;
			mw_a = mem_addr;
			mw_d = mem_wdata;
		end
		swe = swe | status_word_we;
		if (status_word_we != 5'h00) sfl = status_word_out;
	end

	// ******************************************************
	// Tasks
	// ******************************************************
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	task automatic end_sim();
		if (n_errors == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic clr();
		n_fl = 0;
		n_nop = 0;
		n_rw = 0;
		n_mw = 0;
		swe = 5'h00;
	endtask

	// Offers one word and waits until the core is idle.
	task automatic run(input logic [23:0] w, input logic two);
		@(posedge mclk);
		instr_valid <= 1'b1;
		instr_word <= w;
		next_two_word <= two;
		#1 clr();
		@(posedge mclk);
		instr_valid <= 1'b0;
		k = 0;
		do begin
			@(posedge mclk);
			#1 k++;
		end while (instr_ready !== 1'b1 && k < 20);
		if (k >= 20) begin
			n_errors++;
			end_sim();
		end
		// One more edge lets the recorder see the last write.
		@(posedge mclk);
		#1;
	endtask

	function automatic logic [23:0] cmpw(input logic [4:0] c,
		input logic [3:0] w, input logic b, input logic [3:0] s);
		return {4'hE, c, w, b, 6'h00, s};
	endfunction

	// File decrement; byte results compare the low byte.
	task automatic decf_case(input logic d, input logic b,
		input logic [12:0] f, input logic [15:0] v, input logic [15:0] r,
		input logic [4:0] fl);
		logic [15:0] m;
		m = b ? 16'h00FF : 16'hFFFF;
		mem_val = v;
		run({9'h1DA, b, d, f}, 1'b0);
		chk(k, 3);
		chk((d ? mw_d : rw_d) & m, r & m);
		chk(sfl, fl);
		chk({d ? n_mw : n_rw, d ? n_rw : n_mw}, {32'd1, 32'd0});
		chk(d ? 4'h0 : rw_a, 0);
		chk(d ? mw_a : 0, d ? f : 0);
	endtask

	// ******************************************************
	// Main sequence
	// ******************************************************
	initial begin
		mclk = 1'b0;
		rst_n = 1'b0;
		instr_valid = 1'b0;
		instr_word = 24'h000000;
		next_two_word = 1'b0;
		status_word_in = 5'h00;
		mem_val = 16'h0000;
		mem_rdata = 16'h0000;
		rf = '{default: 16'h0000};
		n_errors = 0;
		tests_run = 0;
		clr();
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		#1 chk({instr_ready, flush_next, nop_exec, rf_we, mem_re, mem_we,
			status_word_we, mem_addr}, {1'b1, 26'h0000000});
		rows = '{'{cmpw(5'h0C, 4'hA, 1'b0, 4'h5), 16'h0001, 16'hFFFF, 1, 1},
			'{cmpw(5'h0C, 4'h0, 1'b0, 4'hF), 16'h2600, 16'h2600, 0, 0},
			'{cmpw(5'h0C, 4'hF, 1'b1, 4'h0), 16'h00FF, 16'h26FE, 0, 1},
			'{cmpw(5'h0D, 4'h3, 1'b0, 4'h6), 16'h8000, 16'h7FFF, 1, 1},
			'{cmpw(5'h0D, 4'h8, 1'b1, 4'h9), 16'h0100, 16'h00FF, 0, 0},
			'{cmpw(5'h0E, 4'h2, 1'b1, 4'h3), 16'h1200, 16'h3400, 1, 0},
			'{cmpw(5'h0E, 4'h2, 1'b0, 4'h3), 16'h1200, 16'h3400, 0, 1}};
		foreach (rows[i]) begin
			rf[rows[i].w[14:11]] = rows[i].a;
			rf[rows[i].w[3:0]] = rows[i].b;
			run(rows[i].w, rows[i].two);
			chk(n_fl, rows[i].take);
			chk(n_nop, rows[i].take ? (rows[i].two ? 2 : 1) : 0);
			chk(k, rows[i].take ? (rows[i].two ? 3 : 2) : 1);
			chk(n_rw + n_mw + swe, 0);
		end
		// Decimal adjust on register 3.
		foreach (dadj_t[i]) begin
			rf[3] = {8'h77, dadj_t[i][19:12]};
			status_word_in = {dadj_t[i][3], 3'h0, dadj_t[i][2]};
			run({20'hFD400, 4'h3}, 1'b0);
			chk({rw_a, rw_d[7:0]}, {4'h3, dadj_t[i][11:4]});
			chk({swe, sfl.c}, {5'h01, dadj_t[i][1]});
		end
		status_word_in = 5'h00;
		decf_case(1'b1, 1'b0, 13'h1FFF, 16'h8000, 16'h7FFF, 5'h05);
		decf_case(1'b0, 1'b1, 13'h0200, 16'h80FF, 16'h00FE, 5'h19);
		decf_case(1'b1, 1'b1, 13'h0201, 16'h1200, 16'h00FF, 5'h08);
		// Register decrement, direct modes, down to zero.
		rf[7] = 16'h0001;
		run({9'h1D2, 1'b0, 3'h0, 4'h8, 3'h0, 4'h7}, 1'b0);
		chk({rw_a, rw_d, sfl, swe}, {4'h8, 16'h0000, 5'h13, 5'h1F});
		// Source post-increment, destination post-decrement.
		rf[7] = 16'h2300;
		rf[8] = 16'h2400;
		mem_val = 16'h0107;
		run({9'h1D2, 1'b0, 3'h3, 4'h8, 3'h2, 4'h7}, 1'b0);
		chk({mw_a, mw_d, sfl}, {16'h2400, 16'h0106, 5'h11});
		chk({n_rw, rw_a, rw_d}, {32'd2, 4'h8, 16'h23FE});
		// Words outside the group, or with stray bits, are ignored.
		bad = '{cmpw(5'h0C, 4'hA, 1'b0, 4'h5) | 24'h000010,
			cmpw(5'h0F, 4'h1, 1'b0, 4'h1)};
		foreach (bad[i]) begin
			@(posedge mclk);
			instr_valid <= 1'b1;
			instr_word <= bad[i];
			#1 clr();
			repeat (3) @(posedge mclk);
			instr_valid <= 1'b0;
			#1 chk({instr_ready, n_fl + n_rw}, {1'b1, 32'd0});
		end
		// A reset in the execute cycle cancels a pending skip.
		@(posedge mclk);
		instr_valid <= 1'b1;
		instr_word <= rows[0].w;
		@(posedge mclk);
		instr_valid <= 1'b0;
		rst_n <= 1'b0;
		@(posedge mclk);
		rst_n <= 1'b1;
		#1 clr();
		repeat (3) @(posedge mclk);
		#1 chk({instr_ready, n_fl}, {1'b1, 32'd0});
		end_sim();
	end
endmodule
`default_nettype wire
